// ### verilog/glpwm_pkg.sv
/*
 * Constants for the level-encoding PWM block: register indices, field
 * layouts, reset values, time base codes and bus response codes.
 * Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
 */
`default_nettype none
package glpwm_pkg;
    // ------------------------------------------------------------------
    // Register map: index times four gives the byte address.
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_LOW_CFG = 8'h53;
    localparam logic [7:0] IDX_HIGH_CFG = 8'h54;
    localparam logic [7:0] IDX_CTRL = 8'h60;
    localparam logic [7:0] IDX_STATUS = 8'h61;
    localparam int ADDR_W = 12;
    localparam int WORD_LSB = 2;
    // ------------------------------------------------------------------
    // Fields and reset values.
    // ------------------------------------------------------------------
    localparam int CNT_W = 7;
    localparam int TB_LSB = 14;
    localparam int HC_LSB = 7;
    localparam int LC_LSB = 0;
    localparam logic [15:0] LOW_CFG_RST = 16'h007f;
    localparam logic [15:0] HIGH_CFG_RST = 16'h3f80;
    localparam logic [15:0] HIGH_CFG_MASK = 16'h3fff;
    localparam int CTRL_LEVEL_BIT = 0;
    localparam int CTRL_ENC_BIT = 1;
    // ------------------------------------------------------------------
    // Time base codes and their lengths in clock periods.
    // ------------------------------------------------------------------
    localparam logic [1:0] TB_SEL_16 = 2'h0;
    localparam logic [1:0] TB_SEL_64 = 2'h1;
    localparam logic [1:0] TB_SEL_256 = 2'h2;
    localparam logic [1:0] TB_SEL_1024 = 2'h3;
    localparam int TB_W = 11;
    localparam logic [TB_W-1:0] TB_LEN_16 = 11'h010;
    localparam logic [TB_W-1:0] TB_LEN_64 = 11'h040;
    localparam logic [TB_W-1:0] TB_LEN_256 = 11'h100;
    localparam logic [TB_W-1:0] TB_LEN_1024 = 11'h400;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW, ST_STATIC} glpwm_state_t;
endpackage : glpwm_pkg
`default_nettype wire

// ### verilog/glpwm_top.sv
/*
 * Level-encoding PWM generator for the shared I/O and fault pin, with
 * its configuration registers behind an AXI4-Lite slave.
 * Assumes one clock SYS_CLK and a synchronous active-low reset RST_B;
 * the bus master runs on the same clock.
 */
// Functional notes
// (RL1) Two-bit time base select: 00b=16, 01b=64, 11b=1024 clocks; resets to 00b.
// (RL2) Time base select code 10b gives 256 clock periods.
// (RL3) One time base serves both plain PWM and the level encoder.
// (RL4) Low level: high time is low-level high count times time base; resets 0.
// (RL5) Low level: low time is low-level low count times time base; resets all ones.
// (RL6) High level: high time is high-level high count times base; resets all ones.
// (RL7) High level: low time is high-level low count times time base; resets 0.
// (RL8) Period equals sum of the level's two counts times time base.
// (RL9) High count zero, low count nonzero: output static low.
// (RL10) Low count zero, high count nonzero: output static high.
// (RL11) Both counts zero: output static low.
// (RL12) Bits 15:14 of the high-level register are reserved and read 00b.
// (RL13) Period starts high then low; changes apply at next period boundary.
`timescale 1ns/1ps
`default_nettype none
module glpwm_top (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic SHARED_IO_FAULT_PIN
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [glpwm_pkg::TB_W-1:0] tb_len(input logic [1:0] sel);
        case (sel)
            glpwm_pkg::TB_SEL_16: tb_len = glpwm_pkg::TB_LEN_16;
            glpwm_pkg::TB_SEL_64: tb_len = glpwm_pkg::TB_LEN_64;
            glpwm_pkg::TB_SEL_256: tb_len = glpwm_pkg::TB_LEN_256;
            default: tb_len = glpwm_pkg::TB_LEN_1024;
        endcase
    endfunction : tb_len

    function automatic logic [7:0] word_idx(input logic [11:0] addr);
        word_idx = addr[glpwm_pkg::WORD_LSB +: 8];
    endfunction : word_idx

    logic [15:0] low_cfg_q;
    logic [15:0] high_cfg_q;
    logic level_q;
    logic enc_en_q;
    glpwm_pkg::glpwm_state_t state_q;
    logic [glpwm_pkg::CNT_W-1:0] hc_lat_q;
    logic [glpwm_pkg::CNT_W-1:0] lc_lat_q;
    logic [1:0] tb_lat_q;
    logic [glpwm_pkg::TB_W-1:0] pre_q;
    logic [glpwm_pkg::CNT_W-1:0] cnt_q;
    logic out_q;
    logic tick;
    logic boundary;
    logic [glpwm_pkg::CNT_W-1:0] sel_hc;
    logic [glpwm_pkg::CNT_W-1:0] sel_lc;

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic write_go;
    logic [7:0] widx;

    assign write_go = !AWREADY && !WREADY && !BVALID;
    assign widx = word_idx(awaddr_q);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= glpwm_pkg::RESP_OKAY;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                AWREADY <= 1'b0;
                awaddr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                WREADY <= 1'b0;
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (write_go) begin
                BVALID <= 1'b1;
                if (widx == glpwm_pkg::IDX_LOW_CFG || widx == glpwm_pkg::IDX_HIGH_CFG ||
                    widx == glpwm_pkg::IDX_CTRL || widx == glpwm_pkg::IDX_STATUS) begin
                    BRESP <= glpwm_pkg::RESP_OKAY;
                end else begin
                    BRESP <= glpwm_pkg::RESP_SLVERR;
                end
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // Configuration registers; the status word is read-only and drops writes.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            low_cfg_q <= glpwm_pkg::LOW_CFG_RST; // RL1 RL4 RL5
            high_cfg_q <= glpwm_pkg::HIGH_CFG_RST; // RL6 RL7
            level_q <= 1'b0;
            enc_en_q <= 1'b1;
        end else if (write_go) begin
            if (widx == glpwm_pkg::IDX_LOW_CFG) begin
                if (wstrb_q[0]) low_cfg_q[7:0] <= wdata_q[7:0];
                if (wstrb_q[1]) low_cfg_q[15:8] <= wdata_q[15:8];
            end
            if (widx == glpwm_pkg::IDX_HIGH_CFG) begin
                if (wstrb_q[0]) high_cfg_q[7:0] <= wdata_q[7:0];
                if (wstrb_q[1]) begin
                    high_cfg_q[15:8] <= wdata_q[15:8] & glpwm_pkg::HIGH_CFG_MASK[15:8]; // RL12
                end
            end
            if (widx == glpwm_pkg::IDX_CTRL && wstrb_q[0]) begin
                level_q <= wdata_q[glpwm_pkg::CTRL_LEVEL_BIT];
                enc_en_q <= wdata_q[glpwm_pkg::CTRL_ENC_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= glpwm_pkg::RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RRESP <= glpwm_pkg::RESP_OKAY;
            case (word_idx(ARADDR))
                glpwm_pkg::IDX_LOW_CFG: RDATA <= {16'h0000, low_cfg_q};
                glpwm_pkg::IDX_HIGH_CFG: begin
                    RDATA <= {16'h0000, high_cfg_q & glpwm_pkg::HIGH_CFG_MASK}; // RL12
                end
                glpwm_pkg::IDX_CTRL: RDATA <= {30'h0000_0000, enc_en_q, level_q};
                glpwm_pkg::IDX_STATUS: begin
                    RDATA <= {28'h000_0000, state_q, out_q, tick};
                end
                default: begin
                    RDATA <= 32'h0000_0000;
                    RRESP <= glpwm_pkg::RESP_SLVERR;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // PWM engine
    // ------------------------------------------------------------------
    // Plain PWM mode uses the low-level counts whatever the level is, so
    // both modes share one time base and one engine.
    always_comb begin
        if (enc_en_q && level_q) begin
            sel_hc = high_cfg_q[glpwm_pkg::HC_LSB +: glpwm_pkg::CNT_W]; // RL6
            sel_lc = high_cfg_q[glpwm_pkg::LC_LSB +: glpwm_pkg::CNT_W]; // RL7
        end else begin
            sel_hc = low_cfg_q[glpwm_pkg::HC_LSB +: glpwm_pkg::CNT_W]; // RL4
            sel_lc = low_cfg_q[glpwm_pkg::LC_LSB +: glpwm_pkg::CNT_W]; // RL5
        end
    end

    assign tick = (pre_q == tb_len(tb_lat_q) - 11'h001); // RL1 RL2 RL3
    assign boundary = (state_q == glpwm_pkg::ST_IDLE) || (state_q == glpwm_pkg::ST_STATIC && tick) ||
        (state_q == glpwm_pkg::ST_LOW && tick && cnt_q == lc_lat_q - 7'h01); // RL13

    // The prescaler restarts at each boundary so every period is exact.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B || boundary || tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 11'h001;
        end
    end

    // Settings are latched only at a boundary, so a mid-period write never
    // produces a torn pulse.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            state_q <= glpwm_pkg::ST_IDLE;
            hc_lat_q <= '0;
            lc_lat_q <= '0;
            tb_lat_q <= glpwm_pkg::TB_SEL_16;
            cnt_q <= '0;
            out_q <= 1'b0;
        end else if (boundary) begin
            hc_lat_q <= sel_hc;
            lc_lat_q <= sel_lc;
            tb_lat_q <= low_cfg_q[glpwm_pkg::TB_LSB +: 2]; // RL3
            cnt_q <= '0;
            if (sel_hc == '0 || sel_lc == '0) begin
                state_q <= glpwm_pkg::ST_STATIC;
                out_q <= (sel_hc != '0); // RL9 RL10 RL11
            end else begin
                state_q <= glpwm_pkg::ST_HIGH; // RL13
                out_q <= 1'b1;
            end
        end else if (tick) begin
            case (state_q)
                glpwm_pkg::ST_HIGH: begin
                    if (cnt_q == hc_lat_q - 7'h01) begin
                        state_q <= glpwm_pkg::ST_LOW; // RL8
                        out_q <= 1'b0;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 7'h01;
                    end
                end
                glpwm_pkg::ST_LOW: cnt_q <= cnt_q + 7'h01;
                default: cnt_q <= '0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            SHARED_IO_FAULT_PIN <= 1'b0;
        end else begin
            SHARED_IO_FAULT_PIN <= out_q;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    // A run also restarts when a high phase begins, so a static high level
    // just before the period is not counted as part of its high time.
    logic [16:0] run_q;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B || out_q != $past(out_q) ||
            (state_q == glpwm_pkg::ST_HIGH && $past(state_q) != glpwm_pkg::ST_HIGH)) begin
            run_q <= 17'h00001;
        end else begin
            run_q <= run_q + 17'h00001;
        end
    end

    chk_tb_reset: assert property ($rose(RST_B) |-> low_cfg_q[15:14] == 2'h0) // RL1
        else $error("time base select not cleared by reset");
    chk_tb_256: assert property (tick && tb_lat_q == glpwm_pkg::TB_SEL_256 && !boundary // RL2
        |-> ##255 !tick ##1 tick)
        else $error("256 time base tick misplaced");
    chk_high_time: assert property (state_q == glpwm_pkg::ST_LOW && // RL4 RL6 RL8
        $past(state_q) == glpwm_pkg::ST_HIGH
        |-> run_q == 17'(hc_lat_q) * 17'(tb_len(tb_lat_q)))
        else $error("high phase length wrong");
    chk_low_time: assert property (state_q == glpwm_pkg::ST_HIGH && // RL5 RL7 RL8
        $past(state_q) == glpwm_pkg::ST_LOW
        |=> $past(run_q) == 17'($past(lc_lat_q, 2)) * 17'(tb_len($past(tb_lat_q, 2))))
        else $error("low phase length wrong");
    chk_static_low: assert property (state_q == glpwm_pkg::ST_STATIC && hc_lat_q == '0 |-> !out_q) // RL9 RL11
        else $error("static low level not low");
    chk_static_high: assert property (state_q == glpwm_pkg::ST_STATIC && hc_lat_q != '0 |-> out_q) // RL10
        else $error("static high level not high");
    chk_reserved_read: assert property (ARVALID && ARREADY && // RL12
        word_idx(ARADDR) == glpwm_pkg::IDX_HIGH_CFG
        |=> RVALID && RDATA[15:14] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_phase_order: assert property (state_q == glpwm_pkg::ST_LOW && // RL13
        $past(state_q) != glpwm_pkg::ST_LOW
        |-> $past(state_q) == glpwm_pkg::ST_HIGH)
        else $error("low phase entered without high phase");
    chk_latch_hold: assert property (!boundary |=> $stable(hc_lat_q) && $stable(tb_lat_q)) // RL13 RL3
        else $error("settings changed inside a period");

    cov_toggle: cover property (state_q == glpwm_pkg::ST_HIGH ##[1:300] state_q == glpwm_pkg::ST_LOW);
    cov_static: cover property (state_q == glpwm_pkg::ST_STATIC && out_q);
    cov_level_high: cover property (boundary && level_q && enc_en_q);
    cov_write: cover property (BVALID && BREADY && BRESP == glpwm_pkg::RESP_OKAY);
endmodule : glpwm_top
`default_nettype wire

// ### bench/glpwm_pin_decoder.sv
/*
 * Model of the external controller that decodes the PWM-encoded pin.
 * Assumes the pin is sampled on the same clock as the encoder.
 */
`timescale 1ns/1ps
`default_nettype none
module glpwm_pin_decoder (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    output var int high_len,
    output var int low_len,
    output var int run_len,
    output logic period_done
);
    logic pin_q;
    // ------------------------------------------------------------------
    // Run-length measurement.
    // ------------------------------------------------------------------
    // Each run is counted in samples, so a level held for N clocks reads N.
    always @(posedge clk) begin
        period_done <= 1'b0;
        if (!rst_b) begin
            pin_q <= 1'b0;
            run_len <= 0;
            high_len <= 0;
            low_len <= 0;
        end else begin
            pin_q <= pin;
            if (pin !== pin_q) begin
                run_len <= 1;
                if (pin) begin
                    low_len <= run_len;
                    period_done <= 1'b1;
                end else begin
                    high_len <= run_len;
                end
            end else begin
                run_len <= run_len + 1;
            end
        end
    end
endmodule : glpwm_pin_decoder
`default_nettype wire

// ### bench/glpwm_tb_top.sv
/*
 * Self-checking bench for the level-encoding PWM block: AXI4-Lite master
 * tasks, an integer model of registers and waveform, and a pin decoder.
 * Assumes the package, the design top and the decoder are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module glpwm_tb_top;
    localparam logic [11:0] A_LOW = {2'h0, glpwm_pkg::IDX_LOW_CFG, 2'h0};
    localparam logic [11:0] A_HIGH = {2'h0, glpwm_pkg::IDX_HIGH_CFG, 2'h0};
    localparam logic [11:0] A_CTRL = {2'h0, glpwm_pkg::IDX_CTRL, 2'h0};
    localparam int LIMIT = 60000;
    logic SYS_CLK = 1'b0;
    logic RST_B, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY, SHARED_IO_FAULT_PIN, done_pulse;
    logic [11:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, v;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'hb7fd5d6c;
    int hi_len, lo_len, run_len, low_cfg, high_cfg, ctrl;

    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    glpwm_top dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .SHARED_IO_FAULT_PIN(SHARED_IO_FAULT_PIN));

    glpwm_pin_decoder u_dec (.clk(SYS_CLK), .rst_b(RST_B), .pin(SHARED_IO_FAULT_PIN),
        .high_len(hi_len), .low_len(lo_len), .run_len(run_len), .period_done(done_pulse));

    task automatic summarize();
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            $display("BAD %0t run did not finish", $time);
            summarize();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // ------------------------------------------------------------------
    // Bus master; it starts one edge late so no signal is driven twice.
    // ------------------------------------------------------------------
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        logic mapped;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        mapped = (a == A_LOW || a == A_HIGH || a == A_CTRL);
        @(posedge SYS_CLK);
        AWADDR <= a;
        AWVALID <= 1'b1;
        WDATA <= d;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        // No bound of its own: the cycle ceiling ends a hung handshake.
        forever begin
            @(posedge SYS_CLK);
            if (aw_ok && w_ok && BVALID === 1'b1) begin
                check(BRESP, mapped ? glpwm_pkg::RESP_OKAY : glpwm_pkg::RESP_SLVERR, "bresp");
                BREADY <= 1'b0;
                break;
            end
            if (!aw_ok && AWREADY === 1'b1) begin
                aw_ok = 1'b1;
                AWVALID <= 1'b0;
            end
            if (!w_ok && WREADY === 1'b1) begin
                w_ok = 1'b1;
                WVALID <= 1'b0;
            end
        end
        if (a == A_LOW) low_cfg = d[15:0];
        if (a == A_HIGH) high_cfg = d[13:0];
        if (a == A_CTRL) ctrl = d[1:0];
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ar_ok;
        ar_ok = 1'b0;
        @(posedge SYS_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        forever begin
            @(posedge SYS_CLK);
            if (ar_ok && RVALID === 1'b1) begin
                check(RDATA, exp, "rdata");
                check(RRESP, er, "rresp");
                RREADY <= 1'b0;
                break;
            end
            if (!ar_ok && ARREADY === 1'b1) begin
                ar_ok = 1'b1;
                ARVALID <= 1'b0;
            end
        end
    endtask : axi_read

    // The first full period after a change is the second one that ends.
    task automatic measure();
        int cfg;
        int t;
        int got;
        cfg = (ctrl == 3) ? high_cfg : low_cfg;
        t = 16 << (2 * ((low_cfg >> 14) % 4));
        got = 0;
        // A rise reported in the next two cycles opens a period with old settings.
        repeat (2) @(posedge SYS_CLK);
        while (got < 2) begin
            @(posedge SYS_CLK);
            if (done_pulse === 1'b1) got++;
        end
        check(hi_len, ((cfg >> 7) % 128) * t, "high time");
        check(lo_len, (cfg % 128) * t, "low time");
    endtask : measure

    task automatic static_chk(input logic lvl);
        repeat (400) @(posedge SYS_CLK);
        check(SHARED_IO_FAULT_PIN, lvl, "static level");
        check(run_len >= 200, 1, "static run");
    endtask : static_chk

    initial begin
        {RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h0;
        AWADDR = 12'h0;
        ARADDR = 12'h0;
        WDATA = 32'h0;
        WSTRB = 4'h3;
        low_cfg = 32'h007f;
        high_cfg = 32'h3f80;
        ctrl = 2;
        repeat (8) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        axi_read(A_LOW, low_cfg, glpwm_pkg::RESP_OKAY);
        axi_read(A_HIGH, high_cfg, glpwm_pkg::RESP_OKAY);
        axi_read(12'h004, 32'h0, glpwm_pkg::RESP_SLVERR);
        axi_write(12'h004, 32'hffff_ffff);
        static_chk(1'b0);
        axi_write(A_HIGH, 32'h0000_ffff);
        axi_read(A_HIGH, 32'h0000_3fff, glpwm_pkg::RESP_OKAY);
        for (int c = 3; c >= 0; c--) begin
            axi_write(A_LOW, (c << 14) | (2 << 7) | 3);
            axi_read(A_LOW, low_cfg, glpwm_pkg::RESP_OKAY);
            measure();
        end
        axi_write(A_LOW, 32'h0000_0280);
        static_chk(1'b1);
        axi_write(A_LOW, 32'h0000_0000);
        static_chk(1'b0);
        axi_write(A_HIGH, 32'h0000_0084);
        axi_write(A_CTRL, 32'h0000_0003);
        measure();
        repeat (3) begin
            v = $random(seed);
            axi_write(A_LOW, {16'h0, 1'b0, v[16], v[13:0]});
            axi_write(A_HIGH, {18'h0, 3'h0, {1'b0, v[9:7]} + 4'h1, 3'h0, {1'b0, v[2:0]} + 4'h1});
            measure();
        end
        axi_write(A_LOW, 32'h0000_4283);
        axi_write(A_CTRL, 32'h0000_0001);
        axi_read(A_CTRL, 32'h0000_0001, glpwm_pkg::RESP_OKAY);
        measure();
        summarize();
    end
endmodule : glpwm_tb_top
`default_nettype wire
